// file: bis_cfg.svh
/*
  Address map, field positions, opcodes and phase codes of the branch,
  increment and skip execution slice.
  Assumes inclusion by bare name from the slice's design files.
*/
`ifndef BIS_CFG_SVH
`define BIS_CFG_SVH
`define BIS_A_CTRL 8'h00
`define BIS_A_STATUS 8'h04
`define BIS_A_BANK 8'h08
`define BIS_A_PC 8'h0C
`define BIS_A_PROG 8'h10
`define BIS_A_FADDR 8'h14
`define BIS_A_FDATA 8'h18
`define BIS_A_IDX 8'h1C
`define BIS_CTRL_RUN 0
`define BIS_CTRL_EXT 1
`define BIS_ST_FLAGS 8
`define BIS_ST_RUN 13
`define BIS_FL_C 0
`define BIS_FL_HALF 1
`define BIS_FL_Z 2
`define BIS_FL_RANGE 3
`define BIS_FL_N 4
`define BIS_BIT_D 9
`define BIS_BIT_A 8
`define BIS_OPC_INC 6'h0A
`define BIS_OPC_DEC 6'h13
`define BIS_OPC_JUMP 8'hEF
`define BIS_IDX_LIMIT 8'h5F
`define BIS_ACC_LOW 4'h0
`define BIS_ACC_SFR 4'hF
`define BIS_Q1 2'h0
`define BIS_Q2 2'h1
`define BIS_Q3 2'h2
`define BIS_Q4 2'h3
`define BIS_RESP_OK 2'h0
`define BIS_RESP_ERR 2'h2
`define BIS_STEP_INC 8'h01
`define BIS_STEP_DEC 8'hFF
`endif

// file: bis_pkg.sv
/*
  Types of the execution slice: sequencer states and decoded operations.
  Assumes nothing of its surroundings.
*/
package bis_pkg;
  typedef enum logic [1:0] {BIS_IDLE = 2'b00, BIS_EXEC = 2'b01, BIS_NOP = 2'b10} bis_state_t;
  typedef enum logic [1:0] {
    BIS_OP_NONE = 2'b00,
    BIS_OP_INC = 2'b01,
    BIS_OP_DEC = 2'b10,
    BIS_OP_JUMP = 2'b11
  } bis_op_t;
endpackage : bis_pkg

// file: bis_ram_if.sv
/*
  Single port memory carrier between the slice and its memories.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface bis_ram_if #(parameter int AW = 8, parameter int DW = 8);
  logic [AW-1:0] addr;
  logic we;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : bis_ram_if

// file: bis_ram.sv
/*
  Small synchronous memory with registered read data, one cycle latency.
  Assumes address and write controls are stable around the clock edge.
*/
`timescale 1ns/10ps
module bis_ram #(parameter int AW = 8, parameter int DW = 8) (
  input wire logic clk_sys,
  bis_ram_if.mem port
);
  logic [DW-1:0] store [0:(1<<AW)-1];
  logic [DW-1:0] rdata_reg;

  always_ff @(posedge clk_sys)
  begin
    if (port.we)
    begin
      store[port.addr] <= port.wdata;
    end
    rdata_reg <= store[port.addr];
  end

  assign port.rdata = rdata_reg;
endmodule : bis_ram

// file: bis_alu.sv
/*
  Byte step unit: adds one or subtracts one and derives the status flags.
  Assumes a stable operand; purely combinational.
*/
`timescale 1ns/10ps
`include "bis_cfg.svh"
module bis_alu (
  input wire logic [7:0] val,
  input wire logic dec,
  output logic [7:0] res,
  output logic [4:0] flags
);
  logic [7:0] step;
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb
  begin
    step = dec ? `BIS_STEP_DEC : `BIS_STEP_INC;
    sum = {1'b0, val} + {1'b0, step};
    nib = {1'b0, val[3:0]} + {1'b0, step[3:0]};
    res = sum[7:0];
    flags[`BIS_FL_C] = sum[8];
    flags[`BIS_FL_HALF] = nib[4];
    flags[`BIS_FL_Z] = (sum[7:0] == 8'h00);
    flags[`BIS_FL_RANGE] = (val[7] == step[7]) && (sum[7] != val[7]);
    flags[`BIS_FL_N] = sum[7];
  end
endmodule : bis_alu

// file: bis_core_top.sv
/*
  Execution slice of an 8-bit core: absolute jump, file increment and
  decrement-skip-if-nonzero, sequenced in four phases per instruction cycle,
  with program and file memories loaded and steered over AXI4-Lite.
  Assumes an AXI4-Lite master on clk_sys and a synchronous active high reset.
*/
// How it works
// - Jump loads 20-bit target into PC 20:1
// - Jump: two words, Q4 loads PC, then idle
// - Increment adds one, wraps at all ones
// - Increment updates all five status flags
// - Increment recognised by opcode 0010 10
// - Destination bit picks accumulator or file register
// - Bank bit picks access bank or bank register
// - Extended set, low addresses use indexed offset
// - Increment: one word, one four-phase cycle
// - Skip idles one cycle, two over 2-word
// - Decrement, nonzero result discards next instruction
`timescale 1ns/10ps
`include "bis_cfg.svh"
module bis_core_top #(parameter int PROG_AW = 10) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import bis_pkg::*;

  generate
    // Load register carries a 16-bit word index
    if (PROG_AW < 1 || PROG_AW > 16)
    begin : g_bad_aw
      $error("PROG_AW must lie in 1..16");
    end
  endgenerate

  bis_ram_if #(.AW(PROG_AW), .DW(16)) pm_if();
  bis_ram_if #(.AW(12), .DW(8)) fm_if();

  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic rvalid_reg, rvalid_next, aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next, wdata_reg, wdata_next;
  logic [7:0] waddr_reg, waddr_next;
  logic [3:0] wstrb_reg, wstrb_next, bank_reg, bank_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic [11:0] idx_reg, idx_next, faddr_reg, faddr_next;
  logic sw_wr;
  logic [7:0] wsel;
  logic [31:0] wval;

  bis_state_t state_reg, state_next;
  bis_op_t op_reg, op_next;
  logic [1:0] q_reg, q_next, nops_reg, nops_next;
  logic [15:0] ir_reg, ir_next;
  logic [20:0] pc_reg, pc_next;
  logic [7:0] w_reg, w_next, klo_reg, klo_next, res_reg, res_next;
  logic [4:0] flags_reg, flags_next;
  logic [11:0] ea_reg, ea_next;
  logic [7:0] alu_res;
  logic [4:0] alu_flags;

  bis_ram #(.AW(PROG_AW), .DW(16)) u_prog (.clk_sys(clk_sys), .port(pm_if));
  bis_ram #(.AW(12), .DW(8)) u_file (.clk_sys(clk_sys), .port(fm_if));
  bis_alu u_alu (
    .val(fm_if.rdata),
    .dec(op_reg == BIS_OP_DEC),
    .res(alu_res),
    .flags(alu_flags)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
    begin
      merge[i*8 +: 8] = strb[i] ? val[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return a <= `BIS_A_IDX;
  endfunction : mapped

  function automatic logic is_jump(input logic [15:0] wd);
    return wd[15:8] == `BIS_OPC_JUMP;
  endfunction : is_jump

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    case ({a[7:2], 2'b00})
      `BIS_A_CTRL: rd_word = {30'h0, ctrl_reg};
      `BIS_A_STATUS: rd_word = {18'h0, state_reg != BIS_IDLE, flags_reg, w_reg};
      `BIS_A_BANK: rd_word = {28'h0, bank_reg};
      `BIS_A_PC: rd_word = {11'h0, pc_reg};
      `BIS_A_FADDR: rd_word = {20'h0, faddr_reg};
      `BIS_A_FDATA: rd_word = {24'h0, fm_if.rdata};
      `BIS_A_IDX: rd_word = {20'h0, idx_reg};
      default: rd_word = 32'h0;
    endcase
  endfunction : rd_word

  assign sw_wr = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wsel = {waddr_reg[7:2], 2'b00};

  // Merge follows every register that the read-back function looks at
  always_comb
  begin
    wval = merge(rd_word(waddr_reg), wdata_reg, wstrb_reg);
  end

  // Bus slave and software registers
  always_comb
  begin
    aw_held_next = aw_held_reg ? !sw_wr : (s_axi_awvalid && awready_reg);
    w_held_next = w_held_reg ? !sw_wr : (s_axi_wvalid && wready_reg);
    awready_next = !aw_held_next;
    wready_next = !w_held_next;
    waddr_next = (s_axi_awvalid && awready_reg) ? s_axi_awaddr : waddr_reg;
    wdata_next = (s_axi_wvalid && wready_reg) ? s_axi_wdata : wdata_reg;
    wstrb_next = (s_axi_wvalid && wready_reg) ? s_axi_wstrb : wstrb_reg;
    bvalid_next = sw_wr || (bvalid_reg && !s_axi_bready);
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    bank_next = bank_reg;
    idx_next = idx_reg;
    faddr_next = faddr_reg;
    if (sw_wr)
    begin
      bresp_next = mapped(waddr_reg) ? `BIS_RESP_OK : `BIS_RESP_ERR;
      case (wsel)
        `BIS_A_CTRL: ctrl_next = wval[1:0];
        `BIS_A_BANK: bank_next = wval[3:0];
        `BIS_A_FADDR: faddr_next = wval[11:0];
        `BIS_A_IDX: idx_next = wval[11:0];
        default: ;
      endcase
    end
    rvalid_next = (s_axi_arvalid && arready_reg) || (rvalid_reg && !s_axi_rready);
    arready_next = !rvalid_next;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg)
    begin
      rdata_next = rd_word(s_axi_araddr);
      rresp_next = mapped(s_axi_araddr) ? `BIS_RESP_OK : `BIS_RESP_ERR;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bresp_reg <= `BIS_RESP_OK;
      rresp_reg <= `BIS_RESP_OK;
      rdata_reg <= 32'h0;
      waddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      ctrl_reg <= 2'h0;
      bank_reg <= 4'h0;
      idx_reg <= 12'h0;
      faddr_reg <= 12'h0;
    end
    else
    begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      bresp_reg <= bresp_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      ctrl_reg <= ctrl_next;
      bank_reg <= bank_next;
      idx_reg <= idx_next;
      faddr_reg <= faddr_next;
    end
  end

  // Four-phase sequencer; memories belong to software while idle
  always_comb
  begin
    state_next = state_reg;
    q_next = q_reg + 2'h1;
    op_next = op_reg;
    ir_next = ir_reg;
    pc_next = pc_reg;
    w_next = w_reg;
    flags_next = flags_reg;
    klo_next = klo_reg;
    res_next = res_reg;
    ea_next = ea_reg;
    nops_next = nops_reg;
    fm_if.addr = faddr_reg;
    fm_if.wdata = wdata_reg[7:0];
    fm_if.we = 1'b0;
    pm_if.addr = wdata_reg[16 +: PROG_AW];
    pm_if.wdata = wdata_reg[15:0];
    pm_if.we = 1'b0;
    if (state_reg == BIS_IDLE)
    begin
      q_next = `BIS_Q1;
      fm_if.we = sw_wr && wsel == `BIS_A_FDATA && wstrb_reg[0];
      pm_if.we = sw_wr && wsel == `BIS_A_PROG;
      if (sw_wr && wsel == `BIS_A_PC)
      begin
        pc_next = {wval[20:1], 1'b0};
      end
      if (ctrl_reg[`BIS_CTRL_RUN])
      begin
        state_next = BIS_NOP;
        nops_next = 2'h1;
      end
    end
    else
    begin
      fm_if.addr = ea_reg;
      fm_if.wdata = res_reg;
      pm_if.addr = pc_reg[PROG_AW:1];
      case (q_reg)
        `BIS_Q1:
        begin
          if (state_reg == BIS_EXEC)
          begin
            if (is_jump(ir_reg))
              op_next = BIS_OP_JUMP;
            else if (ir_reg[15:10] == `BIS_OPC_INC)
              op_next = BIS_OP_INC;
            else if (ir_reg[15:10] == `BIS_OPC_DEC)
              op_next = BIS_OP_DEC;
            else
              op_next = BIS_OP_NONE;
            if (ir_reg[`BIS_BIT_A])
              ea_next = {bank_reg, ir_reg[7:0]};
            else if (ctrl_reg[`BIS_CTRL_EXT] && ir_reg[7:0] <= `BIS_IDX_LIMIT)
              ea_next = idx_reg + {4'h0, ir_reg[7:0]};
            else if (ir_reg[7:0] <= `BIS_IDX_LIMIT)
              ea_next = {`BIS_ACC_LOW, ir_reg[7:0]};
            else
              ea_next = {`BIS_ACC_SFR, ir_reg[7:0]};
          end
        end
        `BIS_Q2:
        begin
          if (state_reg == BIS_EXEC && op_reg == BIS_OP_JUMP)
            klo_next = ir_reg[7:0];
        end
        `BIS_Q3:
        begin
          res_next = alu_res;
        end
        default:
        begin
          ir_next = pm_if.rdata;
          pc_next = pc_reg + 21'h2;
          if (state_reg == BIS_EXEC)
          begin
            nops_next = 2'h0;
            case (op_reg)
              BIS_OP_INC, BIS_OP_DEC:
              begin
                fm_if.we = ir_reg[`BIS_BIT_D];
                if (!ir_reg[`BIS_BIT_D])
                  w_next = res_reg;
                if (op_reg == BIS_OP_INC)
                  flags_next = alu_flags;
                // two idles over a 2-word one
                if (op_reg == BIS_OP_DEC && res_reg != 8'h00)
                  nops_next = is_jump(pm_if.rdata) ? 2'h2 : 2'h1;
              end
              BIS_OP_JUMP:
              begin
                pc_next = {pm_if.rdata[11:0], klo_reg, 1'b0};
                nops_next = 2'h1;
              end
              default: ;
            endcase
          end
          else
          begin
            nops_next = nops_reg - 2'h1;
          end
          if (nops_next != 2'h0)
            state_next = BIS_NOP;
          else if (!ctrl_reg[`BIS_CTRL_RUN])
          begin
            state_next = BIS_IDLE;
            pc_next = pc_reg;
          end
          else
            state_next = BIS_EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg <= BIS_IDLE;
      q_reg <= `BIS_Q1;
      op_reg <= BIS_OP_NONE;
      ir_reg <= 16'h0;
      pc_reg <= 21'h0;
      w_reg <= 8'h0;
      flags_reg <= 5'h0;
      klo_reg <= 8'h0;
      res_reg <= 8'h0;
      ea_reg <= 12'h0;
      nops_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      q_reg <= q_next;
      op_reg <= op_next;
      ir_reg <= ir_next;
      pc_reg <= pc_next;
      w_reg <= w_next;
      flags_reg <= flags_next;
      klo_reg <= klo_next;
      res_reg <= res_next;
      ea_reg <= ea_next;
      nops_reg <= nops_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  logic ex_q4;
  assign ex_q4 = state_reg == BIS_EXEC && q_reg == `BIS_Q4;

  property p_jump_target;
    ex_q4 && op_reg == BIS_OP_JUMP |=>
      pc_reg == {$past(pm_if.rdata[11:0]), $past(klo_reg), 1'b0};
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump target wrong");
  property p_jump_idle;
    ex_q4 && op_reg == BIS_OP_JUMP |=> (state_reg == BIS_NOP)[*4];
  endproperty
  a_jump_idle: assert property (p_jump_idle) else $error("jump idle cycle missing");
  property p_inc_wrap;
    state_reg == BIS_EXEC && q_reg == `BIS_Q3 && op_reg == BIS_OP_INC |=>
      res_reg == $past(fm_if.rdata) + 8'h01;
  endproperty
  a_inc_wrap: assert property (p_inc_wrap) else $error("increment result wrong");
  property p_inc_flags;
    ex_q4 && op_reg == BIS_OP_INC |=> flags_reg[`BIS_FL_Z] == ($past(res_reg) == 8'h00)
      && flags_reg[`BIS_FL_C] == ($past(res_reg) == 8'h00)
      && flags_reg[`BIS_FL_N] == $past(res_reg[7])
      && flags_reg[`BIS_FL_HALF] == ($past(res_reg[3:0]) == 4'h0)
      && flags_reg[`BIS_FL_RANGE] == ($past(res_reg) == 8'h80);
  endproperty
  a_inc_flags: assert property (p_inc_flags) else $error("increment flags wrong");
  property p_inc_decode;
    state_reg == BIS_EXEC && q_reg == `BIS_Q1 && ir_reg[15:10] == 6'h0A |=>
      op_reg == BIS_OP_INC;
  endproperty
  a_inc_decode: assert property (p_inc_decode) else $error("increment not decoded");
  property p_dest_sel;
    ex_q4 && op_reg != BIS_OP_NONE && op_reg != BIS_OP_JUMP |->
      fm_if.we == ir_reg[`BIS_BIT_D] ##1 ($past(ir_reg[`BIS_BIT_D]) || w_reg == $past(res_reg));
  endproperty
  a_dest_sel: assert property (p_dest_sel) else $error("destination wrong");
  property p_bank_sel;
    state_reg == BIS_EXEC && q_reg == `BIS_Q2 && ir_reg[`BIS_BIT_A] |->
      ea_reg == {bank_reg, ir_reg[7:0]};
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("banked address wrong");
  property p_indexed;
    state_reg == BIS_EXEC && q_reg == `BIS_Q2 && !ir_reg[`BIS_BIT_A]
      && ctrl_reg[`BIS_CTRL_EXT] && ir_reg[7:0] <= 8'h5F |-> ea_reg == idx_reg + ir_reg[7:0];
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");
  property p_inc_single;
    ex_q4 && op_reg == BIS_OP_INC && ctrl_reg[`BIS_CTRL_RUN] |=>
      state_reg == BIS_EXEC && q_reg == `BIS_Q1;
  endproperty
  a_inc_single: assert property (p_inc_single) else $error("increment not one cycle");
  property p_skip_two;
    ex_q4 && op_reg == BIS_OP_DEC && res_reg != 8'h00 && is_jump(pm_if.rdata) |=>
      (state_reg == BIS_NOP)[*8];
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("double skip too short");
  property p_skip_one;
    ex_q4 && op_reg == BIS_OP_DEC && res_reg != 8'h00 && !is_jump(pm_if.rdata)
      && ctrl_reg[`BIS_CTRL_RUN] |=> (state_reg == BIS_NOP)[*4] ##1 state_reg == BIS_EXEC;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip length wrong");
  property p_idle_quiet;
    state_reg == BIS_NOP |-> !fm_if.we ##1 $stable(w_reg) && $stable(flags_reg);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle cycle changed state");

  c_jump: cover property (ex_q4 && op_reg == BIS_OP_JUMP);
  c_skip2: cover property (ex_q4 && op_reg == BIS_OP_DEC && res_reg != 8'h00
    && is_jump(pm_if.rdata));
  c_inc_wrap: cover property (ex_q4 && op_reg == BIS_OP_INC && res_reg == 8'h00);
endmodule : bis_core_top

// file: bis_axi_master.sv
/*
  AXI4-Lite master model standing in for software: one write or one read at a time.
  Assumes a slave on clk_sys answering through the usual valid/ready handshakes.
*/
`timescale 1ns/10ps
module bis_axi_master (
  input wire logic clk_sys,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  localparam int LIMIT = 200;

  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  task automatic write(input logic [7:0] addr, input logic [31:0] data,
                       output logic [1:0] resp, output bit hung);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    resp = 2'h3;
    @(posedge clk_sys);
    s_axi_awaddr <= addr;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= data;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < LIMIT)
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    hung = !done;
  endtask : write

  task automatic read(input logic [7:0] addr, output logic [31:0] data,
                      output logic [1:0] resp, output bit hung);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    data = 32'h0;
    resp = 2'h3;
    @(posedge clk_sys);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < LIMIT)
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid)
      begin
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    hung = !done;
  endtask : read
endmodule : bis_axi_master

// file: branch_increment_skip_exec_tb.sv
/*
  Self-checking bench of the execution slice: loads programs and file bytes,
  runs the core, then judges file bytes, status and program counter.
  Assumes the slice's register map and the bus master model beside it.
*/
`timescale 1ns/10ps
`include "bis_cfg.svh"
module branch_increment_skip_exec_tb;
  logic clk_sys;
  logic reset;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic [1:0] last_resp;
  int errors = 0;
  int tests_run = 0;

  bis_core_top #(.PROG_AW(10)) bis_core_top_inst (.clk_sys, .reset, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  bis_axi_master bis_axi_master_inst (.clk_sys, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic summarize;
    $display("Counts: %0d checks, %0d mismatches", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic hang(input bit hung);
    if (hung)
    begin
      errors++;
      $display("mismatch wait expected answer seen none");
      summarize();
    end
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit hung;
    bis_axi_master_inst.write(a, d, last_resp, hung);
    hang(hung);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bit hung;
    bis_axi_master_inst.read(a, d, last_resp, hung);
    hang(hung);
  endtask : rd

  task automatic prog(input logic [15:0] idx, input logic [15:0] w);
    wr(`BIS_A_PROG, {idx, w});
  endtask : prog

  task automatic fset(input logic [11:0] f, input logic [7:0] v);
    wr(`BIS_A_FADDR, {20'h0, f});
    wr(`BIS_A_FDATA, {24'h0, v});
  endtask : fset

  task automatic fchk(input logic [11:0] f, input logic [7:0] v);
    logic [31:0] d;
    wr(`BIS_A_FADDR, {20'h0, f});
    repeat (2) @(posedge clk_sys);
    rd(`BIS_A_FDATA, d);
    chk("file byte", d, {24'h0, v});
  endtask : fchk

  // Start at PC 0, let it settle in its closing self-jump, then stop
  task automatic run(input logic [31:0] ctrl);
    logic [31:0] st;
    int n;
    wr(`BIS_A_PC, 32'h0);
    wr(`BIS_A_CTRL, ctrl | 32'h1);
    repeat (80) @(posedge clk_sys);
    rd(`BIS_A_STATUS, st);
    chk("running", {31'h0, st[`BIS_ST_RUN]}, 32'h1);
    wr(`BIS_A_CTRL, ctrl & ~32'h1);
    n = 0;
    st[`BIS_ST_RUN] = 1'b1;
    while (st[`BIS_ST_RUN] !== 1'b0 && n < 50)
    begin
      rd(`BIS_A_STATUS, st);
      n++;
    end
    hang(st[`BIS_ST_RUN] !== 1'b0);
  endtask : run

  task automatic t_bus;
    logic [31:0] d;
    rd(`BIS_A_STATUS, d);
    chk("status at reset", d, 32'h0);
    rd(8'h20, d);
    chk("unmapped rdata", d, 32'h0);
    chk("unmapped rresp", {30'h0, last_resp}, {30'h0, `BIS_RESP_ERR});
    wr(8'h24, 32'hFFFF_FFFF);
    chk("unmapped bresp", {30'h0, last_resp}, {30'h0, `BIS_RESP_ERR});
    $display("test bus done");
  endtask : t_bus

  task automatic t_increment;
    logic [31:0] d;
    wr(`BIS_A_BANK, 32'h2);
    fset(12'h210, 8'h7F);
    fset(12'h211, 8'hFF);
    prog(16'h0, 16'h2910);
    prog(16'h1, 16'h2B11);
    prog(16'h2, 16'h2F10);
    prog(16'h3, 16'hEF03);
    prog(16'h4, 16'hF000);
    run(32'h0);
    rd(`BIS_A_STATUS, d);
    chk("status", d, 32'h0000_0780);
    fchk(12'h211, 8'h00);
    fchk(12'h210, 8'h7F);
    rd(`BIS_A_PC, d);
    chk("pc", d, 32'h6);
    $display("test increment done");
  endtask : t_increment

  task automatic t_skip;
    logic [31:0] d;
    fset(12'h030, 8'h05);
    fset(12'h031, 8'h40);
    fset(12'h032, 8'h01);
    fset(12'h033, 8'h01);
    prog(16'h0, 16'h4E30);
    prog(16'h1, 16'h2A31);
    prog(16'h2, 16'h4E32);
    prog(16'h3, 16'h4C33);
    prog(16'h4, 16'h4E30);
    prog(16'h5, 16'hEF00);
    prog(16'h6, 16'h2A31);
    prog(16'h7, 16'hEF07);
    prog(16'h8, 16'hF000);
    run(32'h0);
    rd(`BIS_A_STATUS, d);
    chk("status", d, 32'h0000_0700);
    fchk(12'h030, 8'h03);
    fchk(12'h031, 8'h40);
    fchk(12'h032, 8'h00);
    fchk(12'h033, 8'h01);
    rd(`BIS_A_PC, d);
    chk("pc", d, 32'hE);
    $display("test skip done");
  endtask : t_skip

  task automatic t_index;
    wr(`BIS_A_IDX, 32'h300);
    fset(12'h320, 8'h0F);
    fset(12'hF80, 8'h22);
    prog(16'h0, 16'h2A20);
    prog(16'h1, 16'h2A80);
    prog(16'h2, 16'hEF02);
    prog(16'h3, 16'hF000);
    run(32'h2);
    fchk(12'h320, 8'h10);
    fchk(12'hF80, 8'h23);
    $display("test index done");
  endtask : t_index

  task automatic t_far_jump;
    logic [31:0] d;
    prog(16'h0, 16'hEF32);
    prog(16'h1, 16'hFF54);
    prog(16'h32, 16'hEF32);
    prog(16'h33, 16'hFF54);
    run(32'h0);
    rd(`BIS_A_PC, d);
    chk("pc", d, 32'h001E_A864);
    rd(`BIS_A_STATUS, d);
    chk("status", d, 32'h0);
    $display("test far jump done");
  endtask : t_far_jump

  initial
  begin
    reset = 1'b1;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    t_bus();
    t_increment();
    t_skip();
    t_index();
    t_far_jump();
    summarize();
  end
endmodule : branch_increment_skip_exec_tb
